// >>> inc/rx_path_pkg.sv
package rx_path_pkg;
	// Register map, byte addresses on the AHB-Lite slave
	localparam logic [7:0] global_config_reg_addr = 8'h00;
	localparam logic [7:0] recovery_select_reg_addr = 8'h04;
	localparam logic [7:0] single_rail_mode2_reg_addr = 8'h08;
	localparam logic [7:0] channel_code_reg_addr = 8'h0c;
	localparam logic [7:0] termination_select_reg_addr = 8'h10;
	localparam logic [7:0] loss_status_reg_addr = 8'h14;
	// Global config field positions
	localparam int gcf_code_pos = 0;
	localparam int gcf_alarm_sub_pos = 1;
	localparam int gcf_e1_pos = 2;
	localparam int gcf_crit_pos = 3;
	// Reset values
	localparam logic [7:0] chan_reg_rst = 8'h00;
	localparam logic [3:0] gcf_rst = 4'h0;
	// Loss-of-signal figures
	localparam int los_t1_zeros = 175;
	localparam int los_e1a_zeros = 32;
	localparam int los_e1b_zeros = 2048;
	localparam int clr_t1_window = 128;
	localparam int clr_t1_marks = 16;
	localparam int clr_t1_run = 99;
	localparam int clr_e1_window = 32;
	localparam int clr_e1_marks = 4;
	localparam int clr_e1_run = 15;
	// DPLL oversampling
	localparam int dpll_ratio = 16;
	localparam logic [3:0] dpll_mid = 4'h8;
	// Loss criteria
	typedef enum logic [1:0] {
		crit_t1 = 2'b00,
		crit_e1a = 2'b01,
		crit_e1b = 2'b11
	} los_crit_t;
	// Bus transfer phases
	typedef enum logic [1:0] {
		ph_idle = 2'b00,
		ph_write = 2'b01,
		ph_read = 2'b11
	} bus_phase_t;
endpackage

// >>> core/mark_window.sv
`timescale 1ns/100ps
// Sliding mark window: shift memory of the last received bits, with a running count
module mark_window #(
	parameter int depth = 128
) (
	// Clock and control
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic clear,
	input wire logic shift,
	input wire logic bit_in,
	// Count out, registered
	output logic [7:0] marks
);
	logic [depth-1:0] hist_reg;
	initial begin
		if (depth < 2 || depth > 255) $error("mark_window depth out of range");
	end
	// Bit history, flushed to zero on clear (a loss criterion change)
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hist_reg <= '0;
		end else if (ce && clear) begin
			hist_reg <= '0;
		end else if (ce && shift) begin
			hist_reg <= {hist_reg[depth-2:0], bit_in};
		end
	end
	// Count tracks new bit in, oldest bit out
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			marks <= 8'h00;
		end else if (ce && clear) begin
			marks <= 8'h00;
		end else if (ce && shift) begin
			marks <= marks + {7'h00, bit_in} - {7'h00, hist_reg[depth-1]};
		end
	end
endmodule

// >>> core/rx_path_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Edge pin high: receive outputs on rising recovered clock, read data on falling
// - Edge pin low: receive outputs on falling recovered clock, read data on rising
// - Receive data, violation rail and serial read data are active high
// - Raw slicer mode: edge pin sets raw pulse polarity
// - Serial host write data is active high, sampled on rising serial clock
// - Transmit data and violation insert sampled on falling transmit clock
// - DPLL samples at sixteen times the line rate
// - Recovery select 0: recover clock, output retimed NRZ data
// - Recovery select 1: raw slicer pulses, their XOR drives clock pin
// - Master clock held high forces raw dual rail mode for all
// - Raw mode: positive slicer to positive rail, negative to negative rail
// - Single rail decodes to data pin; dual rail stays undecoded NRZ
// - Global code 0 selects B8ZS/HDB3, 1 selects AMI
// - Mode-2 bit set: channel code bit overrides global select
// - Dual rail ignores all code selects
// - Loss declared drives loss pin high and status follows
// - Loss onset and clearing both raise interrupt events
// - T1 clears with 16 marks in 128 bits, runs under 100 zeros
// - E1 clears with 4 marks in 32 bits, runs under 16 zeros
// - Host mode offers three criteria, hardware mode only two
// - Alarm substitution set: rails output all ones during loss
// - Alarm substitution set: master clock replaces recovered clock during loss
// - Status changes can each be enabled as interrupt events; here loss_event always pulses, with no enable
// - Single-ended termination only in host mode, per channel bit
module rx_path_ctrl #(
	parameter int chan = 0
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pins from outside (asynchronous)
	input wire logic edge_select_pin,
	input wire logic mclk_high_pin,
	input wire logic host_mode_pin,
	input wire logic single_rail_pin,
	input wire logic slicer_pos,
	input wire logic slicer_neg,
	input wire logic mclk_in,
	// Receive outputs
	output logic recovered_clock_out,
	output logic receive_positive_rail,
	output logic receive_negative_rail,
	output logic loss_indicator_pin,
	output logic loss_event,
	output logic single_ended_term
);
	import rx_path_pkg::*;
	initial begin
		if (chan < 0 || chan > 7) $error("rx_path_ctrl chan must be 0 to 7");
	end
	// Two-flop synchronisers for all pins
	logic [6:0] pin_meta_reg, pin_sync_reg;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin_meta_reg <= 7'h00;
			pin_sync_reg <= 7'h00;
		end else if (ce) begin
			pin_meta_reg <= {mclk_in, slicer_neg, slicer_pos, single_rail_pin,
				host_mode_pin, mclk_high_pin, edge_select_pin};
			pin_sync_reg <= pin_meta_reg;
		end
	end
	logic edge_s, mclk_hi_s, host_s, single_s, pos_s, neg_s, mclk_s;
	assign {mclk_s, neg_s, pos_s, single_s, host_s, mclk_hi_s, edge_s} = pin_sync_reg;
	// Configuration registers
	logic [3:0] gcf_reg;
	logic [7:0] crs_reg, sing_reg, code_reg, srx_reg;
	logic los_reg;
	// Bus address phase capture
	bus_phase_t phase_reg;
	logic [7:0] addr_reg;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			phase_reg <= ph_idle;
			addr_reg <= 8'h00;
		end else if (ce && hready) begin
			if (hsel && htrans[1]) begin
				phase_reg <= hwrite ? ph_write : ph_read;
				addr_reg <= haddr;
			end else begin
				phase_reg <= ph_idle;
			end
		end
	end
	// Read decode, used for the registered read data
	function automatic logic [31:0] read_mux(input logic [7:0] a);
		unique case (a)
			global_config_reg_addr: read_mux = {28'h0, gcf_reg};
			recovery_select_reg_addr: read_mux = {24'h0, crs_reg};
			single_rail_mode2_reg_addr: read_mux = {24'h0, sing_reg};
			channel_code_reg_addr: read_mux = {24'h0, code_reg};
			termination_select_reg_addr: read_mux = {24'h0, srx_reg};
			loss_status_reg_addr: read_mux = {31'h0, los_reg};
			default: read_mux = 32'h0;
		endcase
	endfunction

	// Zero wait states; unmapped reads give zero, unmapped writes dropped
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				hrdata <= read_mux(haddr);
			end
		end
	end

	// Register writes; termination bit only takes effect in host mode
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gcf_reg <= gcf_rst;
			crs_reg <= chan_reg_rst;
			sing_reg <= chan_reg_rst;
			code_reg <= chan_reg_rst;
			srx_reg <= chan_reg_rst;
		end else if (ce && phase_reg == ph_write) begin
			unique case (addr_reg)
				global_config_reg_addr: gcf_reg <= hwdata[3:0];
				recovery_select_reg_addr: crs_reg <= hwdata[7:0];
				single_rail_mode2_reg_addr: sing_reg <= hwdata[7:0];
				channel_code_reg_addr: code_reg <= hwdata[7:0];
				termination_select_reg_addr: srx_reg <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// Mode decode
	logic raw_mode, ami_sel, e1_mode, alarm_sub;
	los_crit_t crit;
	assign raw_mode = mclk_hi_s | (host_s & crs_reg[chan]);
	assign ami_sel = (host_s && sing_reg[chan]) ? code_reg[chan] : gcf_reg[gcf_code_pos];
	assign e1_mode = gcf_reg[gcf_e1_pos];
	assign alarm_sub = gcf_reg[gcf_alarm_sub_pos];
	// Hardware mode has no second E1 criterion
	assign crit = !e1_mode ? crit_t1 :
		((host_s && gcf_reg[gcf_crit_pos]) ? crit_e1b : crit_e1a);

	// DPLL phase: 16 ref clock ticks per bit; realigns on each rising mark edge
	logic [3:0] dpll_reg;
	logic mark_now, mark_prev_reg, bit_tick;
	assign mark_now = pos_s | neg_s;
	assign bit_tick = (dpll_reg == dpll_mid);
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dpll_reg <= 4'h0;
			mark_prev_reg <= 1'b0;
		end else if (ce) begin
			mark_prev_reg <= mark_now;
			if (mark_now && !mark_prev_reg) begin
				dpll_reg <= 4'h1;
			end else begin
				dpll_reg <= dpll_reg + 4'h1;
			end
		end
	end

	// Pulse catch per bit: any mark during the bit period counts
	logic pos_seen_reg, neg_seen_reg, pos_bit_reg, neg_bit_reg, bit_valid_reg;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pos_seen_reg <= 1'b0;
			neg_seen_reg <= 1'b0;
			pos_bit_reg <= 1'b0;
			neg_bit_reg <= 1'b0;
			bit_valid_reg <= 1'b0;
		end else if (ce) begin
			bit_valid_reg <= bit_tick;
			if (bit_tick) begin
				pos_bit_reg <= pos_seen_reg | pos_s;
				neg_bit_reg <= neg_seen_reg | neg_s;
				pos_seen_reg <= 1'b0;
				neg_seen_reg <= 1'b0;
			end else begin
				pos_seen_reg <= pos_seen_reg | pos_s;
				neg_seen_reg <= neg_seen_reg | neg_s;
			end
		end
	end
	logic rx_mark;
	assign rx_mark = pos_bit_reg | neg_bit_reg;

	// Zero run counter on the recovered stream
	logic [11:0] zrun_reg;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			zrun_reg <= 12'h000;
		end else if (ce && bit_valid_reg) begin
			if (rx_mark) begin
				zrun_reg <= 12'h000;
			end else if (zrun_reg != 12'hfff) begin
				zrun_reg <= zrun_reg + 12'h001;
			end
		end
	end

	// Sliding mark windows for both line rates
	logic [7:0] marks_t1, marks_e1;
	logic crit_chg;
	los_crit_t crit_prev_reg;
	assign crit_chg = (crit != crit_prev_reg);
	mark_window #(.depth(clr_t1_window)) win_t1 (
		.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .clear(crit_chg),
		.shift(bit_valid_reg), .bit_in(rx_mark), .marks(marks_t1)
	);
	mark_window #(.depth(clr_e1_window)) win_e1 (
		.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .clear(crit_chg),
		.shift(bit_valid_reg), .bit_in(rx_mark), .marks(marks_e1)
	);

	// Loss thresholds per criterion
	logic [11:0] loss_lim, run_lim;
	logic [7:0] mark_lim, mark_cnt;
	always_comb begin
		unique case (crit)
			crit_t1: loss_lim = 12'(los_t1_zeros);
			crit_e1a: loss_lim = 12'(los_e1a_zeros);
			crit_e1b: loss_lim = 12'(los_e1b_zeros);
			default: loss_lim = 12'(los_t1_zeros);
		endcase
		run_lim = e1_mode ? 12'(clr_e1_run) : 12'(clr_t1_run);
		mark_lim = e1_mode ? 8'(clr_e1_marks) : 8'(clr_t1_marks);
		mark_cnt = e1_mode ? marks_e1 : marks_t1;
	end

	// Loss state per bit; events pulse on both onset and clearing
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			los_reg <= 1'b0;
			loss_event <= 1'b0;
			crit_prev_reg <= crit_t1;
		end else if (ce) begin
			crit_prev_reg <= crit;
			loss_event <= 1'b0;
			if (bit_valid_reg) begin
				if (!los_reg && zrun_reg >= loss_lim) begin
					los_reg <= 1'b1;
					loss_event <= 1'b1;
				end else if (los_reg && mark_cnt >= mark_lim && zrun_reg <= run_lim) begin
					los_reg <= 1'b0;
					loss_event <= 1'b1;
				end
			end
		end
	end

	// Simple AMI / B8ZS / HDB3 decoder on single rail; in B8ZS/HDB3 violating marks become zeros
	logic last_pol_reg, dec_bit;
	logic bpv;
	assign bpv = (pos_bit_reg && last_pol_reg) || (neg_bit_reg && !last_pol_reg);
	assign dec_bit = rx_mark && (ami_sel || !bpv);
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			last_pol_reg <= 1'b0;
		end else if (ce && bit_tick && rx_mark) begin // Outgoing bit only, never the current one
			last_pol_reg <= pos_bit_reg;
		end
	end

	// Internal launch clock: recovered bit clock, half high
	logic rclk_int;
	assign rclk_int = dpll_reg[3];

	// Data selection per mode
	logic pos_next, neg_next, clk_next, lose_sub;
	assign lose_sub = los_reg & alarm_sub;
	always_comb begin
		if (raw_mode) begin
			pos_next = pos_s ^ ~edge_s;
			neg_next = neg_s ^ ~edge_s;
			clk_next = pos_s ^ neg_s;
		end else if (single_s) begin
			pos_next = dec_bit;
			neg_next = bpv & ~ami_sel;
			clk_next = rclk_int;
		end else begin
			pos_next = pos_bit_reg;
			neg_next = neg_bit_reg;
			clk_next = rclk_int;
		end
		if (lose_sub) begin
			pos_next = 1'b1;
			neg_next = 1'b1;
			clk_next = mclk_s;
		end
	end

	// Launch point: rising internal clock when edge pin high, falling when low
	logic rclk_prev_reg, launch;
	assign launch = edge_s ? (rclk_int && !rclk_prev_reg) : (!rclk_int && rclk_prev_reg);
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rclk_prev_reg <= 1'b0;
			receive_positive_rail <= 1'b0;
			receive_negative_rail <= 1'b0;
		end else if (ce) begin
			rclk_prev_reg <= rclk_int;
			if (launch || raw_mode || lose_sub) begin
				receive_positive_rail <= pos_next;
				receive_negative_rail <= neg_next;
			end
		end
	end

	// Registered clock, loss and termination pins
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			recovered_clock_out <= 1'b0;
			loss_indicator_pin <= 1'b0;
			single_ended_term <= 1'b0;
		end else if (ce) begin
			recovered_clock_out <= clk_next;
			loss_indicator_pin <= los_reg;
			single_ended_term <= host_s & srx_reg[chan];
		end
	end

	// Checks
	los_onset_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && !los_reg && bit_valid_reg && zrun_reg >= loss_lim |=> los_reg ##1 loss_indicator_pin)
		else $error("loss not declared after zero run");
	los_event_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && $changed(los_reg) |-> loss_event)
		else $error("loss change without event");
	los_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && $fell(los_reg) |-> $past(mark_cnt) >= $past(mark_lim))
		else $error("loss cleared with too few marks");
	ones_sub_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && lose_sub |=> receive_positive_rail && receive_negative_rail)
		else $error("rails not all ones during loss");
	raw_clk_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && raw_mode && !lose_sub |=> recovered_clock_out == $past(pos_s ^ neg_s))
		else $error("raw clock not xor of rails");
	force_raw_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && mclk_hi_s && !lose_sub |=> receive_positive_rail == $past(pos_s ^ ~edge_s))
		else $error("master clock high did not force raw mode");
	term_host_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && !host_s |=> !single_ended_term)
		else $error("termination outside host mode");
	bit_rate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && bit_valid_reg && !(mark_now && !mark_prev_reg) |=> !bit_valid_reg [*2])
		else $error("bit valid too often");
	code_sel_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && launch && single_s && !raw_mode && !lose_sub && host_s && sing_reg[chan] &&
		code_reg[chan] |=> !receive_negative_rail) else $error("channel code override ignored");
endmodule

// >>> sim/line_source.sv
`timescale 1ns/100ps
// Line model: AMI marks on the slicer levels, one bit every 16 reference cycles
module line_source (
	// Clock
	input wire logic ref_clk,
	// Pattern: a mark every n bits, 0 for a silent line; hold forces static levels
	input wire logic [7:0] mark_every,
	input wire logic hold_en,
	input wire logic [1:0] hold_val,
	// Slicer levels
	output logic slicer_pos,
	output logic slicer_neg
);
	logic [3:0] phase = 4'h0;
	logic [7:0] gap = 8'h00;
	logic pol = 1'b0;
	// RZ half-bit pulses; polarity alternates so only held levels can show a violation
	always @(posedge ref_clk) begin
		phase <= phase + 4'h1;
		if (hold_en) begin
			{slicer_pos, slicer_neg} <= hold_val;
		end else if (phase == 4'h0 && mark_every != 8'h00 && gap == 8'h00) begin
			{slicer_pos, slicer_neg} <= {pol, ~pol};
			pol <= ~pol;
			gap <= mark_every - 8'h01;
		end else if (phase == 4'h0 || phase == 4'h8) begin
			{slicer_pos, slicer_neg} <= 2'b00;
			if (phase == 4'h0 && gap != 8'h00)
				gap <= gap - 8'h01;
		end
	end
endmodule

// >>> sim/t1e1_receive_path_control_tb.sv
`timescale 1ns/100ps
module t1e1_receive_path_control_tb;
	import rx_path_pkg::*;
	localparam int ch = 3;
	localparam int bp = dpll_ratio;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp;
	logic edge_select_pin = 1'b1;
	logic mclk_high_pin = 1'b0;
	logic host_mode_pin = 1'b0;
	logic single_rail_pin = 1'b0;
	logic mclk_in = 1'b0;
	logic slicer_pos, slicer_neg;
	logic recovered_clock_out, receive_positive_rail, receive_negative_rail;
	logic loss_indicator_pin, loss_event, single_ended_term;
	logic [7:0] mark_every = 8'h00;
	logic hold_en = 1'b0;
	logic [1:0] hold_val = 2'b00;
	int err_count = 0;
	int n_checks = 0;
	int ev_count = 0;

	always #12.5 ref_clk = ~ref_clk;

	rx_path_ctrl #(.chan(ch)) dut (.ref_clk, .rstn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.edge_select_pin, .mclk_high_pin, .host_mode_pin, .single_rail_pin, .slicer_pos,
		.slicer_neg, .mclk_in, .recovered_clock_out, .receive_positive_rail,
		.receive_negative_rail, .loss_indicator_pin, .loss_event, .single_ended_term);

	line_source line (.ref_clk, .mark_every, .hold_en, .hold_val, .slicer_pos, .slicer_neg);

	// Count loss events; the pulse lasts one cycle so it is tallied every edge
	always @(posedge ref_clk) begin
		if (loss_event === 1'b1)
			ev_count <= ev_count + 1;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results;
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Single AHB-Lite transfer; waits on hready in both phases, data taken at the last edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	// Pin synchronisers need a few cycles before outputs follow
	task automatic settle;
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic wait_loss(input logic lvl, input int lo, input int hi, input string what);
		int n;
		n = 0;
		while (loss_indicator_pin !== lvl && n <= hi) begin
			@(posedge ref_clk);
			n++;
		end
		check(what, 32'(n >= lo && n <= hi), 32'h1);
	endtask

	task automatic keep_loss(input logic lvl, input int n, input string what);
		int bad;
		bad = 0;
		repeat (n) begin
			@(posedge ref_clk);
			bad += int'(loss_indicator_pin !== lvl);
		end
		check(what, 32'(bad), 32'h0);
	endtask

	task automatic t_regs;
		logic [7:0] a [6] = '{global_config_reg_addr, recovery_select_reg_addr,
			single_rail_mode2_reg_addr, channel_code_reg_addr, termination_select_reg_addr,
			loss_status_reg_addr};
		logic [31:0] m [6] = '{32'hf, 32'hff, 32'hff, 32'hff, 32'hff, 32'h0};
		logic [31:0] q;
		for (int i = 0; i < 6; i++) begin
			xfer(1'b0, a[i], 32'h0, q);
			check("reset value", q, 32'h0);
			wr(a[i], 32'hffff_ffff);
			xfer(1'b0, a[i], 32'h0, q);
			check("read back", q, m[i]);
			wr(a[i], 32'h0);
		end
		wr(8'h18, 32'hffff_ffff);
		xfer(1'b0, 8'h18, 32'h0, q);
		check("unmapped", q, 32'h0);
		check("response", {31'h0, hresp}, 32'h0);
		check("ready", {31'h0, hreadyout}, 32'h1);
		host_mode_pin <= 1'b1;
		wr(termination_select_reg_addr, 32'h1 << ch);
		settle();
		check("termination", {31'h0, single_ended_term}, 32'h1);
		host_mode_pin <= 1'b0;
		settle();
		check("termination hw", {31'h0, single_ended_term}, 32'h0);
		wr(termination_select_reg_addr, 32'h0);
	endtask

	task automatic t_raw;
		logic [1:0] v;
		host_mode_pin <= 1'b1;
		hold_en <= 1'b1;
		wr(recovery_select_reg_addr, 32'h1 << ch);
		for (int k = 0; k < 8; k++) begin
			edge_select_pin <= k[2];
			hold_val <= k[1:0];
			settle();
			v = k[2] ? k[1:0] : ~k[1:0];
			check("raw rails", {30'h0, receive_positive_rail, receive_negative_rail}, 32'(v));
			check("raw clock", {31'h0, recovered_clock_out}, {31'h0, ^k[1:0]});
		end
		wr(recovery_select_reg_addr, 32'h0);
		host_mode_pin <= 1'b0;
		mclk_high_pin <= 1'b1;
		edge_select_pin <= 1'b1;
		hold_val <= 2'b10;
		settle();
		check("forced raw", {30'h0, receive_positive_rail, receive_negative_rail}, 32'h2);
		mclk_high_pin <= 1'b0;
		hold_en <= 1'b0;
	endtask

	task automatic t_dual;
		int np;
		int nn;
		logic lp;
		logic ln;
		np = 0;
		nn = 0;
		mark_every <= 8'd2;
		repeat (32 * bp) @(posedge ref_clk);
		lp = receive_positive_rail;
		ln = receive_negative_rail;
		repeat (64 * bp) begin
			@(posedge ref_clk);
			np += int'(receive_positive_rail === 1'b1 && lp === 1'b0);
			nn += int'(receive_negative_rail === 1'b1 && ln === 1'b0);
			lp = receive_positive_rail;
			ln = receive_negative_rail;
		end
		check("positive marks", 32'(np), 32'd16);
		check("negative marks", 32'(nn), 32'd16);
	endtask

	task automatic t_los_t1;
		logic [31:0] q;
		int e;
		wr(global_config_reg_addr, 32'h2);
		keep_loss(1'b0, 20 * bp, "loss under marks");
		e = ev_count;
		mark_every <= 8'd0;
		wait_loss(1'b1, 171 * bp, 178 * bp, "t1 onset");
		xfer(1'b0, loss_status_reg_addr, 32'h0, q);
		check("loss status", q, 32'h1);
		check("onset event", 32'(ev_count - e), 32'h1);
		check("ais rails", {30'h0, receive_positive_rail, receive_negative_rail}, 32'h3);
		mclk_in <= 1'b1;
		settle();
		check("mclk high", {31'h0, recovered_clock_out}, 32'h1);
		mclk_in <= 1'b0;
		settle();
		check("mclk low", {31'h0, recovered_clock_out}, 32'h0);
		mark_every <= 8'd10;
		keep_loss(1'b1, 300 * bp, "t1 sparse");
		mark_every <= 8'd4;
		wait_loss(1'b0, 0, 130 * bp, "t1 clear");
		settle();
		check("clear event", 32'(ev_count - e), 32'h2);
	endtask

	task automatic t_los_e1;
		wr(global_config_reg_addr, 32'h4);
		mark_every <= 8'd2;
		keep_loss(1'b0, 40 * bp, "e1 marks");
		mark_every <= 8'd0;
		wait_loss(1'b1, 29 * bp, 35 * bp, "e1 onset");
		settle();
		check("sliced rails", {30'h0, receive_positive_rail, receive_negative_rail}, 32'h0);
		mark_every <= 8'd11;
		keep_loss(1'b1, 100 * bp, "e1 sparse");
		mark_every <= 8'd8;
		wait_loss(1'b0, 0, 70 * bp, "e1 clear");
	endtask

	task automatic t_crit(input logic host, input int lo, input int hi);
		host_mode_pin <= host;
		wr(global_config_reg_addr, 32'hc);
		mark_every <= 8'd2;
		wait_loss(1'b0, 0, 64 * bp, "crit clear");
		keep_loss(1'b0, 40 * bp, "crit marks");
		mark_every <= 8'd0;
		wait_loss(1'b1, lo * bp, hi * bp, "crit onset");
	endtask

	// Positive marks every other bit: each repeats the last polarity, so each is a violation
	task automatic viol_run(output int nd, output int nv, output int nb);
		logic ld;
		logic lv;
		nd = 0;
		nv = 0;
		nb = 0;
		ld = receive_positive_rail;
		lv = receive_negative_rail;
		for (int c = 0; c < 24 * bp; c++) begin
			@(posedge ref_clk);
			hold_val <= (c % (2 * bp) < bp / 2) ? 2'b10 : 2'b00;
			if (c >= 8 * bp) begin
				nd += int'(receive_positive_rail === 1'b1 && ld === 1'b0);
				nv += int'(receive_negative_rail === 1'b1 && lv === 1'b0);
				nb += int'((receive_positive_rail !== ld || receive_negative_rail !== lv)
					&& recovered_clock_out !== edge_select_pin);
			end
			ld = receive_positive_rail;
			lv = receive_negative_rail;
		end
	endtask

	// Single rail: the code selects decide between data and violation flag
	task automatic t_single;
		int nd;
		int nv;
		int nb;
		host_mode_pin <= 1'b1;
		single_rail_pin <= 1'b1;
		hold_en <= 1'b1;
		hold_val <= 2'b00;
		wr(single_rail_mode2_reg_addr, 32'h1 << ch);
		wr(channel_code_reg_addr, 32'h1 << ch);
		viol_run(nd, nv, nb);
		check("override ami data", 32'(nd), 32'd8);
		check("override ami flag", 32'(nv), 32'd0);
		check("rising launch", 32'(nb), 32'd0);
		edge_select_pin <= 1'b0;
		wr(channel_code_reg_addr, 32'h0);
		wr(global_config_reg_addr, 32'h1);
		viol_run(nd, nv, nb);
		check("override coded data", 32'(nd), 32'd0);
		check("override coded flag", 32'(nv), 32'd8);
		check("falling launch", 32'(nb), 32'd0);
		wr(single_rail_mode2_reg_addr, 32'h0);
		viol_run(nd, nv, nb);
		check("global ami data", 32'(nd), 32'd8);
		check("global ami flag", 32'(nv), 32'd0);
		wr(global_config_reg_addr, 32'h0);
		viol_run(nd, nv, nb);
		check("global coded data", 32'(nd), 32'd0);
		check("global coded flag", 32'(nv), 32'd8);
		edge_select_pin <= 1'b1;
		single_rail_pin <= 1'b0;
		host_mode_pin <= 1'b0;
		hold_en <= 1'b0;
		hold_val <= 2'b00;
	endtask

	// Watchdog sized well past the expected run of about 50k cycles
	initial begin
		repeat (80000) @(posedge ref_clk);
		err_count++;
		results();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs();
		t_raw();
		t_dual();
		t_single();
		t_los_t1();
		t_los_e1();
		t_crit(1'b1, 2044, 2052);
		t_crit(1'b0, 29, 35);
		results();
	end
endmodule
